// [src/mbc_buffer_ctrl.sv]
// Purpose: control bytes, flags and DMA word layout of the CAN message buffers
// Assumes: protocol engine on the same clock; DMA RAM answers reads next cycle
// Notes:   eight buffers carry control bytes; all 32 may receive
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
module mbc_buffer_ctrl (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      arst_n_i,
  // register port
  input  wire logic [mbc_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [15:0]               reg_rdata_o,
  // receive side of the protocol engine
  input  wire logic                      rx_valid_i,
  input  wire mbc_pkg::mbc_rx_s          rx_frame_i,
  output logic                           rx_ready_o,
  input  wire logic                      rtr_hit_i,
  input  wire logic [mbc_pkg::BUF_W-1:0] rtr_buf_i,
  // transmit side of the protocol engine
  output logic                           tx_valid_o,
  output logic      [mbc_pkg::CTL_W-1:0] tx_buf_o,
  output mbc_pkg::mbc_txf_s              tx_frame_o,
  output logic                           tx_abort_o,
  input  wire logic                      tx_evt_i,
  input  wire mbc_pkg::mbc_txev_s        tx_evt_info_i,
  // DMA RAM port
  output logic     [mbc_pkg::DMA_AW-1:0] dma_addr_o,
  output logic      [15:0]               dma_wdata_o,
  output logic                           dma_wr_o,
  output logic                           dma_rd_o,
  input  wire logic [15:0]               dma_rdata_i
);
  import mbc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_FETCH, ST_WAIT} mbc_state_e;

  mbc_ctrl_s            ctl_r   [NCTL];
  mbc_ctrl_s            ctl_nxt [NCTL];
  logic [NCTL-1:0]      abt_pend_r, abt_pend_nxt;
  logic [NBUF-1:0]      full_r, full_nxt, ovf_r, ovf_nxt;
  mbc_state_e           st_r, st_nxt;
  logic [WRD_W-1:0]     cnt_r;
  mbc_rx_s              rxq_r;
  logic [CTL_W-1:0]     act_buf_r, best;
  logic                 tx_act_r, found, rx_acc, rx_ovf;
  logic [1:0]           best_pri;
  logic                 rd_pend_r;
  logic [WRD_W-1:0]     rd_idx_r;
  logic [15:0]          st_word;

  // incoming frame taken only while the DMA engine is idle
  assign rx_acc = rx_valid_i && rx_ready_o;
  assign rx_ovf = rx_acc && full_r[rx_frame_i.buf_idx];

  // pending transmit buffer with the highest priority, ties to highest index
  always_comb begin
    found    = 1'b0;
    best     = '0;
    best_pri = '0;
    for (int i = 0; i < NCTL; i++) begin
      if (ctl_r[i].buffer_direction_select && ctl_r[i].send_request &&
          !abt_pend_r[i] && (!found || ctl_r[i].transmit_priority >= best_pri)) begin
        found    = 1'b1;
        best     = CTL_W'(i);
        best_pri = ctl_r[i].transmit_priority;
      end
    end
  end

  // next value of each control byte: software first, hardware sets win
  always_comb begin
    abt_pend_nxt = abt_pend_r;
    for (int i = 0; i < NCTL; i++) begin
      mbc_ctrl_s wb;
      wb         = (i % 2 == 1) ? reg_wdata_i[15:8] : reg_wdata_i[7:0];
      ctl_nxt[i] = ctl_r[i];
      if (reg_wr_i && reg_addr_i == A_CTRL_BASE + REG_AW'(i / 2)) begin
        ctl_nxt[i].buffer_direction_select  = wb.buffer_direction_select;
        ctl_nxt[i].auto_remote_reply_enable = wb.auto_remote_reply_enable;
        ctl_nxt[i].transmit_priority        = wb.transmit_priority;
        if (wb.send_request && !ctl_r[i].send_request) begin
          ctl_nxt[i].send_request            = 1'b1;
          ctl_nxt[i].message_aborted_flag    = 1'b0;
          ctl_nxt[i].arbitration_lost_flag   = 1'b0;
          ctl_nxt[i].transmit_bus_error_flag = 1'b0;
        end else if (!wb.send_request && ctl_r[i].send_request) begin
          abt_pend_nxt[i] = 1'b1;
        end
      end
      // remote frame auto reply
      if (rtr_hit_i && rtr_buf_i == BUF_W'(i) && ctl_r[i].auto_remote_reply_enable) begin
        ctl_nxt[i].send_request            = 1'b1;
        ctl_nxt[i].message_aborted_flag    = 1'b0;
        ctl_nxt[i].arbitration_lost_flag   = 1'b0;
        ctl_nxt[i].transmit_bus_error_flag = 1'b0;
      end
      // abort of a buffer not on the bus completes at once
      if (abt_pend_r[i] && !(tx_act_r && act_buf_r == CTL_W'(i))) begin
        ctl_nxt[i].send_request         = 1'b0;
        ctl_nxt[i].message_aborted_flag = 1'b1;
        abt_pend_nxt[i]                 = 1'b0;
      end
      // outcome of the attempt on the bus
      if (tx_act_r && tx_evt_i && act_buf_r == CTL_W'(i)) begin
        if (tx_evt_info_i.arb_lost) ctl_nxt[i].arbitration_lost_flag = 1'b1;
        if (tx_evt_info_i.bus_err) ctl_nxt[i].transmit_bus_error_flag = 1'b1;
        if (tx_evt_info_i.sent_ok) begin
          ctl_nxt[i].send_request         = 1'b0;
          ctl_nxt[i].message_aborted_flag = 1'b0;
          abt_pend_nxt[i]                 = 1'b0;
        end else if (tx_evt_info_i.aborted) begin
          ctl_nxt[i].send_request         = 1'b0;
          ctl_nxt[i].message_aborted_flag = 1'b1;
          abt_pend_nxt[i]                 = 1'b0;
        end
      end
    end
  end

  // control bytes and abort requests
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NCTL; i++) ctl_r[i] <= CTRL_RST;
      abt_pend_r <= '0;
    end else begin
      for (int i = 0; i < NCTL; i++) ctl_r[i] <= ctl_nxt[i];
      abt_pend_r <= abt_pend_nxt;
    end
  end

  // full and overflow: software writes zero to clear, a set wins
  always_comb begin
    full_nxt = full_r;
    ovf_nxt  = ovf_r;
    if (reg_wr_i) begin
      if (reg_addr_i == A_FULL_LO) full_nxt[15:0] = full_r[15:0] & reg_wdata_i;
      else if (reg_addr_i == A_FULL_HI) full_nxt[31:16] = full_r[31:16] & reg_wdata_i;
      else if (reg_addr_i == A_OVF_LO) ovf_nxt[15:0] = ovf_r[15:0] & reg_wdata_i;
      else if (reg_addr_i == A_OVF_HI) ovf_nxt[31:16] = ovf_r[31:16] & reg_wdata_i;
    end
    if (st_r == ST_STORE && cnt_r == W_STAT) full_nxt[rxq_r.buf_idx] = 1'b1;
    if (rx_ovf) ovf_nxt[rx_frame_i.buf_idx] = 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      full_r <= '0;
      ovf_r  <= '0;
    end else begin
      full_r <= full_nxt;
      ovf_r  <= ovf_nxt;
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i < A_FULL_LO)
        reg_rdata_o <= {ctl_r[{reg_addr_i[1:0], 1'b1}], ctl_r[{reg_addr_i[1:0], 1'b0}]};
      else if (reg_addr_i == A_FULL_LO) reg_rdata_o <= full_r[15:0];
      else if (reg_addr_i == A_FULL_HI) reg_rdata_o <= full_r[31:16];
      else if (reg_addr_i == A_OVF_LO) reg_rdata_o <= ovf_r[15:0];
      else if (reg_addr_i == A_OVF_HI) reg_rdata_o <= ovf_r[31:16];
      else reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // word of a received frame as laid out in DMA RAM
  always_comb begin
    st_word = '0;
    case (cnt_r)
      W_SID:   st_word = {3'h0, rxq_r.sid, rxq_r.srr, rxq_r.ide};
      W_EID:   st_word = {4'h0, rxq_r.eid[17:6]};
      W_DLC:   st_word = {rxq_r.eid[5:0], rxq_r.rtr, rxq_r.reserved_protocol_bit_high,
                          3'h0, rxq_r.reserved_protocol_bit_low, rxq_r.dlc};
      W_STAT:  st_word = {3'h0, rxq_r.matching_filter_code, 8'h00};
      default: st_word = rxq_r.data[16*(cnt_r-W_DAT0) +: 16];
    endcase
  end

  // DMA engine: store a received frame or fetch a transmit frame
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (rx_acc && !rx_ovf) st_nxt = ST_STORE;
                else if (!rx_acc && found && !tx_act_r) st_nxt = ST_FETCH;
      ST_STORE: if (cnt_r == W_STAT) st_nxt = ST_IDLE;
      ST_FETCH: if (cnt_r == W_DLAST) st_nxt = ST_WAIT;
      ST_WAIT:  if (rd_pend_r) st_nxt = ST_IDLE;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= ST_IDLE;
      cnt_r      <= '0;
      rx_ready_o <= 1'b0;
      rxq_r      <= '0;
    end else begin
      st_r       <= st_nxt;
      rx_ready_o <= (st_nxt == ST_IDLE);
      cnt_r      <= (st_nxt == st_r && st_r != ST_IDLE) ? cnt_r + 1'b1 : '0;
      if (rx_acc) rxq_r <= rx_frame_i;
    end
  end

  // DMA port driven from flops
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_addr_o  <= '0;
      dma_wdata_o <= '0;
      dma_wr_o    <= 1'b0;
      dma_rd_o    <= 1'b0;
    end else begin
      dma_wr_o    <= (st_r == ST_STORE);
      dma_rd_o    <= (st_r == ST_FETCH);
      dma_wdata_o <= st_word;
      if (st_r == ST_STORE) dma_addr_o <= {rxq_r.buf_idx, cnt_r};
      else dma_addr_o <= {BUF_W'(act_buf_r), cnt_r};
    end
  end

  // read data arrives the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend_r <= 1'b0;
      rd_idx_r  <= '0;
    end else begin
      rd_pend_r <= dma_rd_o && dma_addr_o[WRD_W-1:0] == W_DLAST;
      rd_idx_r  <= dma_addr_o[WRD_W-1:0];
    end
  end

  // fetched words collect into the transmit frame
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_frame_o <= '0;
    end else if (st_r == ST_FETCH || st_r == ST_WAIT) begin
      case (rd_idx_r)
        W_SID:   tx_frame_o.sid_w <= dma_rdata_i;
        W_EID:   tx_frame_o.eid_w <= dma_rdata_i;
        W_DLC:   tx_frame_o.dlc_w <= dma_rdata_i;
        default: tx_frame_o.data_w[16*(rd_idx_r-W_DAT0) +: 16] <= dma_rdata_i;
      endcase
    end
  end

  // transmit attempt: buffer chosen at fetch, frame offered after last word
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_act_r   <= 1'b0;
      act_buf_r  <= '0;
      tx_valid_o <= 1'b0;
      tx_buf_o   <= '0;
      tx_abort_o <= 1'b0;
    end else begin
      if (st_r == ST_IDLE && st_nxt == ST_FETCH) begin
        tx_act_r  <= 1'b1;
        act_buf_r <= best;
      end else if (tx_act_r && tx_evt_i) begin
        tx_act_r <= 1'b0;
      end
      tx_valid_o <= tx_act_r && !tx_evt_i && (tx_valid_o || (st_r == ST_WAIT && rd_pend_r));
      tx_buf_o   <= act_buf_r;
      tx_abort_o <= tx_act_r && !tx_evt_i && abt_pend_nxt[act_buf_r];
    end
  end

  // a_req_clears_flags: a newly raised request starts with clean flags
  a_req_clears_flags: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_wr_i && reg_addr_i == A_CTRL_BASE + 4'h1 && reg_wdata_i[11]
     && !ctl_r[3].send_request && !tx_act_r)
    |=> (ctl_r[3].send_request && !ctl_r[3].message_aborted_flag
     && !ctl_r[3].arbitration_lost_flag && !ctl_r[3].transmit_bus_error_flag))
    else $error("send request did not clear status flags");

  a_ok_clears_req: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (tx_act_r && tx_evt_i && tx_evt_info_i.sent_ok) |=>
      (!ctl_r[$past(act_buf_r)].send_request && !ctl_r[$past(act_buf_r)].message_aborted_flag))
    else $error("successful send left request or abort flag set");

  a_arb_lost_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (tx_act_r && tx_evt_i && tx_evt_info_i.arb_lost) |=>
      ctl_r[$past(act_buf_r)].arbitration_lost_flag)
    else $error("lost arbitration not flagged");

  a_bus_err_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (tx_act_r && tx_evt_i && tx_evt_info_i.bus_err) |=>
      ctl_r[$past(act_buf_r)].transmit_bus_error_flag)
    else $error("bus error not flagged");

  a_rtr_reply: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (rtr_hit_i && rtr_buf_i == 5'h01 && ctl_r[1].auto_remote_reply_enable && !reg_wr_i
     && !abt_pend_r[1] && !tx_act_r) |=> ctl_r[1].send_request)
    else $error("remote frame did not raise send request");

  a_store_full: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (rx_acc && !rx_ovf) |-> ##9 full_r[$past(rx_frame_i.buf_idx, 9)])
    else $error("stored frame did not set full flag");

  a_ovf_on_full: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    rx_ovf |=> (ovf_r[$past(rx_frame_i.buf_idx)] && st_r == ST_IDLE))
    else $error("write to full buffer not flagged as overflow");

  a_sid_layout: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dma_wr_o && dma_addr_o[2:0] == W_SID) |-> dma_wdata_o[15:13] == 3'h0)
    else $error("identifier word upper bits not zero");

  a_filter_code: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dma_wr_o && dma_addr_o[2:0] == W_STAT) |->
      (dma_wdata_o[12:8] == rxq_r.matching_filter_code && dma_wdata_o[7:0] == 8'h00))
    else $error("status word filter code wrong");

  a_fetch_dir_tx: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(tx_act_r) |-> ctl_r[act_buf_r].buffer_direction_select)
    else $error("receive buffer chosen for transmission");

endmodule

// [src/mbc_pkg.sv]
// Purpose: shared constants and carriers for the message buffer control block
// Assumes: 16-bit register port, 16-bit DMA RAM words, one clock
// Notes:   each buffer takes eight DMA words; index = buffer*8 + word
package mbc_pkg;

  // buffer counts
  localparam int NBUF     = 32;  // buffers in DMA RAM
  localparam int NCTL     = 8;   // buffers with a control byte
  localparam int BUF_W    = 5;
  localparam int CTL_W    = 3;
  localparam int WRD_W    = 3;
  localparam int DMA_AW   = BUF_W + WRD_W;

  // register port map (word index)
  localparam int          REG_AW      = 4;
  localparam logic [3:0]  A_CTRL_BASE = 4'h0;  // four pair-control words
  localparam logic [3:0]  A_FULL_LO   = 4'h4;
  localparam logic [3:0]  A_FULL_HI   = 4'h5;
  localparam logic [3:0]  A_OVF_LO    = 4'h6;
  localparam logic [3:0]  A_OVF_HI    = 4'h7;

  // word slots of one buffer in DMA RAM
  localparam logic [2:0]  W_SID   = 3'h0;
  localparam logic [2:0]  W_EID   = 3'h1;
  localparam logic [2:0]  W_DLC   = 3'h2;
  localparam logic [2:0]  W_DAT0  = 3'h3;
  localparam logic [2:0]  W_DLAST = 3'h6;  // last word a transmit fetch needs
  localparam logic [2:0]  W_STAT  = 3'h7;

  // control byte reset value
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // one buffer control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       buffer_direction_select;   // 1 transmit, 0 receive
    logic       message_aborted_flag;
    logic       arbitration_lost_flag;
    logic       transmit_bus_error_flag;
    logic       send_request;
    logic       auto_remote_reply_enable;
    logic [1:0] transmit_priority;         // 11 highest, 00 lowest
  } mbc_ctrl_s;

  // received frame from the protocol engine
  typedef struct packed {
    logic [4:0]  buf_idx;
    logic [4:0]  matching_filter_code;
    logic [10:0] sid;
    logic        srr;
    logic        ide;
    logic [17:0] eid;
    logic        rtr;
    logic        reserved_protocol_bit_high;
    logic        reserved_protocol_bit_low;
    logic [3:0]  dlc;
    logic [63:0] data;                     // byte m at bits 8m+7:8m
  } mbc_rx_s;

  // frame fetched for transmission, raw buffer words
  typedef struct packed {
    logic [15:0] sid_w;
    logic [15:0] eid_w;
    logic [15:0] dlc_w;
    logic [63:0] data_w;                   // word k at bits 16k+15:16k
  } mbc_txf_s;

  // end of one transmit attempt
  typedef struct packed {
    logic sent_ok;
    logic aborted;
    logic arb_lost;
    logic bus_err;
  } mbc_txev_s;

endpackage

// [testbench/can_message_buffer_control_tb.sv]
// Purpose: self-checking bench for the message buffer control block
// Assumes: far model stands for DMA RAM and the protocol engine
// Notes:   random frames and control bytes from a fixed seed; priorities swept over every pair
`timescale 1ns/1ns
module can_message_buffer_control_tb;
  import mbc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr, reg_rd, rx_valid, rx_ready, rtr_hit, tx_valid, tx_abort, tx_evt, dma_wr, dma_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dma_wdata, dma_rdata;
  logic [7:0] dma_addr;
  logic [4:0] rtr_buf;
  logic [2:0] tx_buf, got_buf;
  logic [1:0] fault;
  logic [5:0] delay;
  logic [31:0] full_exp;
  mbc_rx_s rx_frame;
  mbc_txf_s tx_frame;
  mbc_txev_s tx_info;
  integer seed = 32'hAAB5;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  mbc_buffer_ctrl dut_u (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rx_valid_i(rx_valid),
    .rx_frame_i(rx_frame), .rx_ready_o(rx_ready), .rtr_hit_i(rtr_hit), .rtr_buf_i(rtr_buf),
    .tx_valid_o(tx_valid), .tx_buf_o(tx_buf), .tx_frame_o(tx_frame), .tx_abort_o(tx_abort),
    .tx_evt_i(tx_evt), .tx_evt_info_i(tx_info), .dma_addr_o(dma_addr),
    .dma_wdata_o(dma_wdata), .dma_wr_o(dma_wr), .dma_rd_o(dma_rd), .dma_rdata_i(dma_rdata));
  mbc_far_model far_u (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .fault_i(fault), .delay_i(delay),
    .dma_addr_i(dma_addr), .dma_wdata_i(dma_wdata), .dma_wr_i(dma_wr), .dma_rd_i(dma_rd),
    .dma_rdata_o(dma_rdata), .tx_valid_i(tx_valid), .tx_abort_i(tx_abort),
    .tx_evt_o(tx_evt), .tx_evt_info_o(tx_info));

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // register port cycles
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(64'(reg_rdata), 64'(exp), what);
  endtask

  // bounded wait for tx_valid to reach a level
  task automatic tx_wait(input logic lvl);
    int n;
    n = 0;
    #1;
    while (tx_valid !== lvl && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 200) chk(64'h0, 64'h1, "transmit handshake wait");
    got_buf = tx_buf;
  endtask

  // offer a frame until taken, then wait for the store to finish
  task automatic rx_send(input mbc_rx_s f);
    int n;
    n = 0;
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge sys_clk);
    while (!rx_ready) @(posedge sys_clk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    while (rx_ready !== 1'b1 && n < 30) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 30) chk(64'h0, 64'h1, "receive store wait");
    // status word lands one edge after ready returns
    @(posedge sys_clk);
    #1;
  endtask

  // expected DMA word k of a stored frame
  function automatic logic [15:0] rx_word(input mbc_rx_s f, input int k);
    case (k)
      0: return {3'h0, f.sid, f.srr, f.ide};
      1: return {4'h0, f.eid[17:6]};
      2: return {f.eid[5:0], f.rtr, f.reserved_protocol_bit_high, 3'h0,
                 f.reserved_protocol_bit_low, f.dlc};
      7: return {3'h0, f.matching_filter_code, 8'h00};
      default: return f.data[16*(k-3) +: 16];
    endcase
  endfunction

  // run limit
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    mbc_rx_s f;
    logic [127:0] rv;
    logic [15:0] w;
    {reg_wr, reg_rd, rx_valid, rtr_hit} = 4'h0;
    {reg_addr, reg_wdata, rtr_buf, fault, delay, rx_frame} = '0;
    delay = 6'h02;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // reset values, unmapped index, read-only flags
    for (int a = 0; a < 8; a++) rchk(4'(a), 16'h0000, "reset value");
    reg_write(4'h9, 16'hFFFF);
    rchk(4'h9, 16'h0000, "unmapped index");
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed));
      reg_write(A_CTRL_BASE + 4'h2, w & 16'hF7F7);
      rchk(A_CTRL_BASE + 4'h2, w & 16'h8787, "control pair");
    end
    // request on a receive buffer is never sent; clearing it aborts at once
    reg_write(A_CTRL_BASE + 4'h2, 16'h0008);
    reg_write(A_CTRL_BASE + 4'h2, 16'h0000);
    rchk(A_CTRL_BASE + 4'h2, 16'h0040, "abort off bus");
    // received frames land in DMA RAM
    full_exp = 32'h0;
    for (int i = 0; i < 4; i++) begin
      rv = {$random(seed), $random(seed), $random(seed), $random(seed)};
      f = rv[111:0];
      f.buf_idx = 5'(8 + i * 6);
      f.reserved_protocol_bit_high = 1'b0;
      f.reserved_protocol_bit_low = 1'b0;
      f.dlc = 4'($unsigned($random(seed)) % 9);
      rx_send(f);
      full_exp[f.buf_idx] = 1'b1;
      for (int k = 0; k < 8; k++)
        chk(64'(far_u.mem[{f.buf_idx, 3'(k)}]), 64'(rx_word(f, k)), "rx word");
    end
    rchk(A_FULL_LO, full_exp[15:0], "full low");
    rchk(A_FULL_HI, full_exp[31:16], "full high");
    // second frame into a full buffer
    w = far_u.mem[8'h40];
    f.buf_idx = 5'h08;
    f.sid = ~f.sid;
    rx_send(f);
    chk(64'(far_u.mem[8'h40]), 64'(w), "overflow kept data");
    rchk(A_OVF_LO, 16'h0100, "overflow flag");
    reg_write(A_FULL_LO, 16'hFEFF);
    rchk(A_FULL_LO, full_exp[15:0] & 16'hFEFF, "full clear");
    reg_write(A_OVF_LO, 16'h0000);
    rchk(A_OVF_LO, 16'h0000, "overflow clear");
    // priority over every code pair, ties to the higher buffer
    for (int k = 0; k < 7; k++) far_u.mem[8'h18 + k] = 16'($random(seed));
    for (int i = 0; i < 16; i++) begin
      w = {8'h88 | 8'(i % 4), 8'h88 | 8'(i / 4)};
      reg_write(A_CTRL_BASE + 4'h1, w);
      tx_wait(1'b1);
      chk(64'(got_buf), (i / 4 > i % 4) ? 64'h2 : 64'h3, "first winner");
      if (got_buf == 3'h3) begin
        chk(64'({tx_frame.sid_w, tx_frame.eid_w, tx_frame.dlc_w}),
            64'({far_u.mem[8'h18], far_u.mem[8'h19], far_u.mem[8'h1A]}), "fetch");
        chk(tx_frame.data_w, {far_u.mem[8'h1E], far_u.mem[8'h1D], far_u.mem[8'h1C],
            far_u.mem[8'h1B]}, "fetch data");
      end
      tx_wait(1'b0);
      tx_wait(1'b1);
      chk(64'(got_buf), (i / 4 > i % 4) ? 64'h3 : 64'h2, "second winner");
      tx_wait(1'b0);
      rchk(A_CTRL_BASE + 4'h1, w & 16'h8383, "request done");
    end
    // arbitration loss, then bus error, each retried to success
    for (int e = 1; e < 3; e++) begin
      fault <= 2'(e);
      reg_write(A_CTRL_BASE + 4'h1, 16'h8800);
      rchk(A_CTRL_BASE + 4'h1, 16'h8800, "flags cleared by request");
      tx_wait(1'b1);
      tx_wait(1'b0);
      fault <= 2'h0;
      tx_wait(1'b1);
      tx_wait(1'b0);
      rchk(A_CTRL_BASE + 4'h1, (e == 1) ? 16'hA000 : 16'h9000, "fault flag");
    end
    // abort while on the bus
    delay <= 6'h28;
    reg_write(A_CTRL_BASE + 4'h1, 16'h8800);
    tx_wait(1'b1);
    reg_write(A_CTRL_BASE + 4'h1, 16'h8000);
    repeat (3) @(posedge sys_clk);
    #1 chk(64'(tx_abort), 64'h1, "abort raised");
    tx_wait(1'b0);
    rchk(A_CTRL_BASE + 4'h1, 16'hC000, "aborted flag");
    // remote frame with auto reply on, then off
    for (int e = 0; e < 2; e++) begin
      reg_write(A_CTRL_BASE, (e == 0) ? 16'h8400 : 16'h8000);
      @(posedge sys_clk);
      rtr_hit <= 1'b1;
      rtr_buf <= 5'h01;
      @(posedge sys_clk);
      rtr_hit <= 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 chk(64'({tx_valid, tx_buf}), (e == 0) ? 64'h9 : 64'h1, "auto reply");
      tx_wait(1'b0);
      rchk(A_CTRL_BASE, (e == 0) ? 16'h8400 : 16'h8000, "auto reply request");
    end
    // success after an abort clears the aborted flag
    delay <= 6'h02;
    reg_write(A_CTRL_BASE + 4'h1, 16'h8800);
    tx_wait(1'b1);
    tx_wait(1'b0);
    rchk(A_CTRL_BASE + 4'h1, 16'h8000, "aborted cleared");
    results();
  end
endmodule

// [testbench/mbc_far_model.sv]
// Purpose: DMA RAM and protocol engine stand-in for the buffer control bench
// Assumes: engine ends each attempt delay_i + 1 cycles after tx_valid_i rises
// Notes:   fault_i 0 sent, 1 arbitration lost, 2 bus error
`timescale 1ns/1ns
module mbc_far_model (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  // bench knobs
  input  wire logic [1:0]   fault_i,
  input  wire logic [5:0]   delay_i,
  // DMA RAM side
  input  wire logic [7:0]   dma_addr_i,
  input  wire logic [15:0]  dma_wdata_i,
  input  wire logic         dma_wr_i,
  input  wire logic         dma_rd_i,
  output logic      [15:0]  dma_rdata_o,
  // engine side
  input  wire logic         tx_valid_i,
  input  wire logic         tx_abort_i,
  output logic              tx_evt_o,
  output mbc_pkg::mbc_txev_s tx_evt_info_o
);
  import mbc_pkg::*;
  logic [15:0] mem [0:255];
  logic [5:0]  cnt_r;
  logic        done_r;
  initial dma_rdata_o = 16'hA5A5;
  // ram: read data stands one cycle only, then toggles
  always @(posedge sys_clk_i) begin
    if (dma_wr_i) mem[dma_addr_i] <= dma_wdata_i;
    dma_rdata_o <= dma_rd_i ? mem[dma_addr_i] : ~dma_rdata_o;
  end
  // engine: one report per attempt, info toggles outside the pulse
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 6'h00;
      done_r <= 1'b0;
      tx_evt_o <= 1'b0;
      tx_evt_info_o <= '0;
    end else begin
      tx_evt_o <= 1'b0;
      tx_evt_info_o <= ~tx_evt_info_o;
      if (!tx_valid_i) begin
        cnt_r <= 6'h00;
        done_r <= 1'b0;
      end else if (!done_r && cnt_r == delay_i) begin
        tx_evt_o <= 1'b1;
        done_r <= 1'b1;
        tx_evt_info_o <= tx_abort_i ? 4'h4 : (fault_i == 2'h1) ? 4'h2 :
                         (fault_i == 2'h2) ? 4'h1 : 4'h8;
      end else if (!done_r) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule
